// ===== src/synth_serial_config_regs.sv
`timescale 1ns/1ns
module synth_serial_config_regs
    import synth_cfg_pkg::*;
#(
    parameter int NUM_SEGMENTS = MAX_SEGMENTS
) (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        clk_en,
    input  wire logic        serial_clk,
    input  wire logic        serial_data,
    input  wire logic        load_strobe,
    input  wire logic        modulation_pin_in,
    input  wire logic        ramp_enable,
    input  wire logic [23:0] ramp_numerator,
    input  wire logic [2:0]  ramp_segment,
    input  wire logic [1:0]  modulator_order,
    input  wire logic [1:0]  dither_select,
    input  wire logic [23:0] sigma_delta_numerator,
    input  wire logic [24:0] sigma_delta_denominator,
    input  wire logic [23:0] modulation_offset,
    input  wire logic        modulation_is_phase,
    input  wire logic [1:0]  readback_pin_select,
    output logic             modulation_pin_out,
    output logic             modulation_pin_oe,
    output logic             multiplexed_output_pin,
    output logic             trigger_pin_one_out,
    output logic             trigger_pin_one_oe,
    output logic             trigger_pin_two_out,
    output logic             trigger_pin_two_oe,
    output logic [1:0]       sleep_control,
    output logic             soft_reset_pulse,
    output logic [7:0]       feedback_divider_low,
    output logic             fractional_active,
    output logic [24:0]      effective_denominator,
    output logic [23:0]      effective_numerator,
    output logic [23:0]      phase_offset,
    output logic [2:0]       active_segment,
    output logic             ramp_running
);

    if (NUM_SEGMENTS < 1 || NUM_SEGMENTS > MAX_SEGMENTS)
    begin : g_check
        $error("synth_serial_config_regs: NUM_SEGMENTS out of range");
    end

    localparam logic [3:0] SEG_LIMIT = 4'(NUM_SEGMENTS);

    // ----------------------------------------------------------------
    // State types
    // ----------------------------------------------------------------
    typedef struct packed {
        link_phase_type phase;
        logic [3:0]     cnt;
        logic           rd;
        logic [14:0]    addr;
        logic [6:0]     byte_sr;
        logic [7:0]     rb_sr;
        logic           rb_on;
        logic           mod_out;
        logic           mod_oe;
        logic           mux_out;
        logic           t1_out;
        logic           t1_oe;
        logic           t2_out;
        logic           t2_oe;
    } link_state_type;

    typedef struct packed {
        logic [7:0] ctrl_s1;
        logic [7:0] ctrl_s2;
        logic [7:0] ndiv_s1;
        logic [7:0] ndiv_s2;
        logic [1:0] sel_s1;
        logic [1:0] sel_s2;
    } link_sync_type;

    typedef struct packed {
        logic        le_s1;
        logic        le_s2;
        logic        mod_s1;
        logic        mod_s2;
        logic        pend_valid;
        logic [14:0] pend_addr;
        logic [7:0]  pend_data;
        logic [7:0]  ctrl;
        logic [7:0]  ndiv;
        logic        srst;
        logic [24:0] den;
        logic        frac_on;
        logic [23:0] num;
        logic [23:0] phase;
        logic [2:0]  seg;
        logic        ramp_on;
    } core_state_type;

    localparam link_state_type LINK_RESET = '{
        phase: PH_HEADER, default: '0};
    localparam core_state_type CORE_RESET = '{
        ctrl: CTRL_RESET, ndiv: NDIV_RESET, den: DEN_MAX, default: '0};

    link_state_type l_reg;
    link_state_type l_next;
    link_sync_type  s_reg;
    link_sync_type  s_next;
    core_state_type c_reg;
    core_state_type c_next;

    logic                  wr_en;
    logic [ENTRY_BITS-1:0] wr_data;
    logic                  rd_valid;
    logic [ENTRY_BITS-1:0] rd_data;

    function automatic logic [7:0] reg_value(
        input logic [14:0] a,
        input logic [7:0]  ctrl,
        input logic [7:0]  ndiv
    );
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            ADDR_FIXED: v = FIXED_VALUE;
            ADDR_CTRL:  v = ctrl;
            ADDR_NDIV:  v = ndiv;
            default:    v = 8'h00;
        endcase
        return v;
    endfunction

    // ----------------------------------------------------------------
    // Link side: frame decode and readback, serial clock domain
    // ----------------------------------------------------------------
    // Each completed write byte leaves immediately: the clock may stop
    // right after the last bit, so nothing may wait for a later edge.
    assign wr_en   = (l_reg.phase == PH_DATA) && (l_reg.cnt == 4'(BYTE_LAST))
                     && !l_reg.rd;
    assign wr_data = {l_reg.addr, l_reg.byte_sr, serial_data};

    always_comb
    begin
        logic [14:0] hdr_addr;
        logic [7:0]  rb_bit_src;
        logic        bit_out;
        hdr_addr   = {l_reg.addr[13:0], serial_data};
        rb_bit_src = 8'h00;
        bit_out    = 1'b0;
        l_next     = l_reg;
        s_next.ctrl_s1 = c_reg.ctrl;
        s_next.ctrl_s2 = s_reg.ctrl_s1;
        s_next.ndiv_s1 = c_reg.ndiv;
        s_next.ndiv_s2 = s_reg.ndiv_s1;
        s_next.sel_s1  = readback_pin_select;
        s_next.sel_s2  = s_reg.sel_s1;
        unique case (l_reg.phase)
            PH_HEADER:
            begin
                if (l_reg.cnt == 4'h0)
                    l_next.rd = serial_data;
                else
                    l_next.addr = hdr_addr;
                l_next.cnt = l_reg.cnt + 4'h1;
                if (l_reg.cnt == 4'(HDR_LAST))
                begin
                    l_next.phase = PH_DATA;
                    l_next.cnt   = 4'h0;
                    if (l_reg.rd)
                    begin
                        l_next.rb_sr = reg_value(hdr_addr, s_reg.ctrl_s2,
                                                 s_reg.ndiv_s2);
                        l_next.rb_on = 1'b1;
                    end
                end
            end
            PH_DATA:
            begin
                l_next.byte_sr = {l_reg.byte_sr[5:0], serial_data};
                l_next.rb_sr   = {l_reg.rb_sr[6:0], 1'b0};
                l_next.cnt     = l_reg.cnt + 4'h1;
                if (l_reg.cnt == 4'(BYTE_LAST))
                begin
                    l_next.cnt  = 4'h0;
                    l_next.addr = l_reg.addr - 15'h0001;
                    if (l_reg.rd)
                        l_next.rb_sr = reg_value(l_reg.addr - 15'h0001,
                                                 s_reg.ctrl_s2,
                                                 s_reg.ndiv_s2);
                end
            end
        endcase
        rb_bit_src = l_next.rb_sr;
        bit_out    = rb_bit_src[7];
        // Readback steering to one pin only
        l_next.mod_out = l_next.rb_on && (s_reg.sel_s2 == RB_MOD)
                         && bit_out;
        l_next.mod_oe  = l_next.rb_on && (s_reg.sel_s2 == RB_MOD);
        l_next.mux_out = l_next.rb_on && (s_reg.sel_s2 == RB_MUX)
                         && bit_out;
        l_next.t1_out  = l_next.rb_on && (s_reg.sel_s2 == RB_TRIGGER_PIN_ONE)
                         && bit_out;
        l_next.t1_oe   = l_next.rb_on && (s_reg.sel_s2 == RB_TRIGGER_PIN_ONE);
        l_next.t2_out  = l_next.rb_on && (s_reg.sel_s2 == RB_TRIGGER_PIN_TWO)
                         && bit_out;
        l_next.t2_oe   = l_next.rb_on && (s_reg.sel_s2 == RB_TRIGGER_PIN_TWO);
    end

    // Strobe high ends the frame and releases the readback pins
    always_ff @(posedge serial_clk or negedge resetn or posedge load_strobe)
    begin
        if (!resetn)
            l_reg <= LINK_RESET;
        else if (load_strobe)
            l_reg <= LINK_RESET;
        else
            l_reg <= l_next;
    end

    // Register copies are quasi-static; 15 edges precede their first use
    always_ff @(posedge serial_clk or negedge resetn)
    begin
        if (!resetn)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    frame_word_fifo #(
        .WIDTH     (ENTRY_BITS),
        .DEPTH_LOG (FIFO_DEPTH_LOG)
    ) u_fifo (
        .wr_clk   (serial_clk),
        .rd_clk   (ref_clk),
        .resetn   (resetn),
        .wr_en    (wr_en),
        .wr_data  (wr_data),
        .rd_en    (clk_en),
        .rd_valid (rd_valid),
        .rd_data  (rd_data)
    );

    // ----------------------------------------------------------------
    // Core side: commit, registers and mode logic, reference clock
    // ----------------------------------------------------------------
    always_comb
    begin
        logic        commit;
        logic [24:0] freq_add;
        logic [23:0] base_num;
        commit   = 1'b0;
        freq_add = 25'h0000000;
        base_num = 24'h000000;
        c_next   = c_reg;
        if (clk_en)
        begin
            c_next.le_s1  = load_strobe;
            c_next.le_s2  = c_reg.le_s1;
            c_next.mod_s1 = modulation_pin_in;
            c_next.mod_s2 = c_reg.mod_s1;
            c_next.srst   = 1'b0;
            // A later byte proves the earlier one belongs to the frame
            commit = c_reg.pend_valid && (rd_valid || c_reg.le_s2);
            if (commit)
            begin
                c_next.pend_valid = 1'b0;
                if (c_reg.pend_addr == ADDR_CTRL)
                begin
                    if (c_reg.pend_data[SOFT_RESET_POS])
                    begin
                        c_next.ctrl = CTRL_RESET;
                        c_next.ndiv = NDIV_RESET;
                        c_next.srst = 1'b1;
                    end
                    else
                    begin
                        c_next.ctrl = {6'h00,
                            c_reg.pend_data[SLEEP_MSB:SLEEP_LSB]};
                    end
                end
                else if (c_reg.pend_addr == ADDR_NDIV)
                begin
                    c_next.ndiv = c_reg.pend_data;
                end
            end
            if (rd_valid)
            begin
                c_next.pend_valid = 1'b1;
                c_next.pend_addr  = rd_data[ENTRY_BITS-1:DATA_BITS];
                c_next.pend_data  = rd_data[DATA_BITS-1:0];
            end

            c_next.ramp_on = ramp_enable;
            if (ramp_enable)
                c_next.den = DEN_FORCED;
            else if (sigma_delta_denominator >= DEN_MIN &&
                     sigma_delta_denominator <= DEN_MAX)
                c_next.den = sigma_delta_denominator;
            // Integer division only when every fractional control is zero
            c_next.frac_on = ramp_enable || (|modulator_order) ||
                             (|dither_select) ||
                             (|sigma_delta_numerator);
            // Ramp inputs count only while the ramp runs
            base_num = ramp_enable ? ramp_numerator
                                   : sigma_delta_numerator;
            if (c_reg.mod_s2 && !modulation_is_phase)
                freq_add = {1'b0, base_num} + {1'b0, modulation_offset};
            else
                freq_add = {1'b0, base_num};
            c_next.num   = freq_add[23:0];
            c_next.phase = (c_reg.mod_s2 && modulation_is_phase)
                           ? modulation_offset : 24'h000000;
            if (!ramp_enable)
                c_next.seg = 3'h0;
            else if ({1'b0, ramp_segment} < SEG_LIMIT)
                c_next.seg = ramp_segment;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            c_reg <= CORE_RESET;
        else
            c_reg <= c_next;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign modulation_pin_out     = l_reg.mod_out;
    assign modulation_pin_oe      = l_reg.mod_oe;
    assign multiplexed_output_pin = l_reg.mux_out;
    assign trigger_pin_one_out    = l_reg.t1_out;
    assign trigger_pin_one_oe     = l_reg.t1_oe;
    assign trigger_pin_two_out    = l_reg.t2_out;
    assign trigger_pin_two_oe     = l_reg.t2_oe;
    assign sleep_control          = c_reg.ctrl[SLEEP_MSB:SLEEP_LSB];
    assign soft_reset_pulse       = c_reg.srst;
    assign feedback_divider_low   = c_reg.ndiv;
    assign fractional_active      = c_reg.frac_on;
    assign effective_denominator  = c_reg.den;
    assign effective_numerator    = c_reg.num;
    assign phase_offset           = c_reg.phase;
    assign active_segment         = c_reg.seg;
    assign ramp_running           = c_reg.ramp_on;

endmodule

// ===== pkg/synth_cfg_pkg.sv
package synth_cfg_pkg;

    localparam int ADDR_BITS = 15;
    localparam int DATA_BITS = 8;
    localparam int HDR_LAST  = 15;
    localparam int BYTE_LAST = 7;
    localparam int ENTRY_BITS = ADDR_BITS + DATA_BITS;

    localparam logic [14:0] ADDR_FIXED = 15'h0000;
    localparam logic [14:0] ADDR_CTRL  = 15'h0002;
    localparam logic [14:0] ADDR_NDIV  = 15'h0010;

    localparam logic [7:0] FIXED_VALUE = 8'h18;
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [7:0] NDIV_RESET  = 8'h00;

    localparam int SOFT_RESET_POS = 2;
    localparam int SLEEP_LSB      = 0;
    localparam int SLEEP_MSB      = 1;

    localparam logic [24:0] DEN_MIN    = 25'h0000001;
    localparam logic [24:0] DEN_MAX    = 25'h1000000;
    localparam logic [24:0] DEN_FORCED = 25'h1000000;

    localparam int MAX_SEGMENTS = 8;
    localparam int FIFO_DEPTH_LOG = 3;

    localparam logic [1:0] RB_MOD   = 2'h0;
    localparam logic [1:0] RB_MUX   = 2'h1;
    localparam logic [1:0] RB_TRIGGER_PIN_ONE = 2'h2;
    localparam logic [1:0] RB_TRIGGER_PIN_TWO = 2'h3;

    typedef enum logic [1:0] {
        PH_HEADER = 2'b01,
        PH_DATA   = 2'b10
    } link_phase_type;

endpackage

// ===== src/frame_word_fifo.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Dual-clock word store, gray pointers, registered read data
// ----------------------------------------------------------------
module frame_word_fifo #(
    parameter int WIDTH     = 23,
    parameter int DEPTH_LOG = 3
) (
    input  wire logic             wr_clk,
    input  wire logic             rd_clk,
    input  wire logic             resetn,
    input  wire logic             wr_en,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             rd_en,
    output logic                  rd_valid,
    output logic      [WIDTH-1:0] rd_data
);

    localparam int DEPTH = 1 << DEPTH_LOG;

    if (DEPTH_LOG < 2 || WIDTH < 1)
    begin : g_check
        $error("frame_word_fifo: unsupported geometry");
    end

    logic [WIDTH-1:0]   mem [DEPTH];
    logic [DEPTH_LOG:0] wbin_reg;
    logic [DEPTH_LOG:0] wgray_reg;
    logic [DEPTH_LOG:0] rbin_reg;
    logic [DEPTH_LOG:0] rgray_reg;
    logic [DEPTH_LOG:0] wsync1_reg;
    logic [DEPTH_LOG:0] wsync2_reg;
    logic [DEPTH_LOG:0] wbin_next;
    logic [DEPTH_LOG:0] rbin_next;
    logic               empty;

    assign wbin_next = wbin_reg + 1'b1;
    assign rbin_next = rbin_reg + 1'b1;
    assign empty     = (rgray_reg == wsync2_reg);

    // ----------------------------------------------------------------
    // Write side, serial clock
    // ----------------------------------------------------------------
    always_ff @(posedge wr_clk)
    begin
        if (wr_en)
            mem[wbin_reg[DEPTH_LOG-1:0]] <= wr_data;
    end

    always_ff @(posedge wr_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wbin_reg  <= '0;
            wgray_reg <= '0;
        end
        else if (wr_en)
        begin
            wbin_reg  <= wbin_next;
            wgray_reg <= wbin_next ^ (wbin_next >> 1);
        end
    end

    // ----------------------------------------------------------------
    // Read side; no full check, drain outpaces serial byte rate
    // ----------------------------------------------------------------
    always_ff @(posedge rd_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wsync1_reg <= '0;
            wsync2_reg <= '0;
            rbin_reg   <= '0;
            rgray_reg  <= '0;
            rd_valid   <= 1'b0;
            rd_data    <= '0;
        end
        else if (rd_en)
        begin
            wsync1_reg <= wgray_reg;
            wsync2_reg <= wsync1_reg;
            rd_valid   <= !empty;
            if (!empty)
            begin
                rd_data   <= mem[rbin_reg[DEPTH_LOG-1:0]];
                rbin_reg  <= rbin_next;
                rgray_reg <= rbin_next ^ (rbin_next >> 1);
            end
        end
    end

endmodule

// ===== verification/synth_cfg_sva.sv
`timescale 1ns/1ns
module synth_cfg_sva
    import synth_cfg_pkg::*;
#(
    parameter int NUM_SEGMENTS = MAX_SEGMENTS
) (
    input wire logic        ref_clk,
    input wire logic        resetn,
    input wire logic        clk_en,
    input wire logic        load_strobe,
    input wire logic        ramp_enable,
    input wire logic [1:0]  modulator_order,
    input wire logic [1:0]  dither_select,
    input wire logic [23:0] sigma_delta_numerator,
    input wire logic [24:0] sigma_delta_denominator,
    input wire logic        modulation_is_phase,
    input wire logic        modulation_pin_oe,
    input wire logic        multiplexed_output_pin,
    input wire logic        trigger_pin_one_oe,
    input wire logic        trigger_pin_two_oe,
    input wire logic [1:0]  sleep_control,
    input wire logic        soft_reset_pulse,
    input wire logic [7:0]  feedback_divider_low,
    input wire logic        fractional_active,
    input wire logic [24:0] effective_denominator,
    input wire logic [23:0] phase_offset,
    input wire logic [2:0]  active_segment,
    input wire logic        ramp_running
);
    // --------------------
    // Mode and link checks
    // --------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    AST_RAMP_FOLLOW: assert property (
        clk_en |=> ramp_running == $past(ramp_enable))
        else $error("ramp_running does not follow ramp_enable");
    AST_FRAC_ON: assert property (
        clk_en && ramp_enable |=> fractional_active)
        else $error("fractional path off while ramping");
    AST_FRAC_OFF: assert property (
        clk_en && !ramp_enable && modulator_order == 2'h0
        && dither_select == 2'h0 && sigma_delta_numerator == 24'h0
        |=> !fractional_active)
        else $error("fractional path left on in integer mode");
    AST_DEN_ACCEPT: assert property (
        clk_en && !ramp_enable && sigma_delta_denominator != 25'h0
        && sigma_delta_denominator <= 25'h1000000
        |=> effective_denominator == $past(sigma_delta_denominator))
        else $error("valid denominator not taken");
    AST_DEN_HOLD: assert property (
        clk_en && !ramp_enable && !ramp_running
        && (sigma_delta_denominator == 25'h0
        || sigma_delta_denominator > 25'h1000000)
        |=> $stable(effective_denominator))
        else $error("out-of-range denominator changed output");
    AST_RAMP_DEN: assert property (
        ramp_running |-> effective_denominator == 25'h1000000)
        else $error("denominator not forced while ramping");
    AST_SEG_RANGE: assert property (
        active_segment < NUM_SEGMENTS
        && (ramp_running || active_segment == 3'h0))
        else $error("segment index out of range");
    AST_PHASE_ZERO: assert property (
        clk_en && !modulation_is_phase |=> phase_offset == 24'h0)
        else $error("phase offset in frequency mode");
    AST_SOFT_CLEAR: assert property (
        soft_reset_pulse |-> ##[0:2]
        (sleep_control == 2'h0 && feedback_divider_low == 8'h00))
        else $error("soft reset left registers set");
    AST_PULSE_ONE: assert property (
        soft_reset_pulse |=> !soft_reset_pulse)
        else $error("soft reset pulse too long");
    AST_RB_IDLE: assert property (
        load_strobe [*2] |-> !modulation_pin_oe && !trigger_pin_one_oe
        && !trigger_pin_two_oe && !multiplexed_output_pin)
        else $error("readback driven outside a frame");
    AST_FREEZE: assert property (
        !clk_en |=> $stable(ramp_running)
        && $stable(effective_denominator) && $stable(feedback_divider_low))
        else $error("core state moved while clock enable low");
endmodule

// ===== verification/host_cfg_model.sv
`timescale 1ns/1ns
module host_cfg_model (
    output logic      serial_clk,
    output logic      serial_data,
    output logic      load_strobe,
    input  wire logic rb_line
);
    // --------------------
    // Serial host
    // --------------------
    initial
    begin
        serial_clk  = 1'b0;
        serial_data = 1'b0;
        load_strobe = 1'b1;
    end

    // Clock idles low; readback sampled late in the high phase of edges 16 to 23
    task automatic xfer(input logic [135:0] v, input int n,
                        output logic [7:0] rb);
        int i;
        rb = 8'h00;
        load_strobe = 1'b0;
        #7;
        for (i = n - 1; i >= 0; i--)
        begin
            serial_data = v[i];
            #7 serial_clk = 1'b1;
            #8;
            if (n - i >= 16 && n - i <= 23)
                rb = {rb[6:0], rb_line};
            serial_clk = 1'b0;
        end
        #7 load_strobe = 1'b1;
        serial_data = ~serial_data;
        #400;
    endtask
endmodule

// ===== verification/tb.sv
`timescale 1ns/1ns
module tb
    import synth_cfg_pkg::*;
;
    localparam int NSEG = 6;
    logic        ref_clk, resetn, clk_en, modulation_pin_in, ramp_enable;
    logic        modulation_is_phase, serial_clk, serial_data, load_strobe;
    logic        modulation_pin_out, modulation_pin_oe, multiplexed_output_pin;
    logic        trigger_pin_one_out, trigger_pin_one_oe, trigger_pin_two_out;
    logic        trigger_pin_two_oe, soft_reset_pulse, fractional_active;
    logic        ramp_running, rb_line, prev_ramp;
    logic [23:0] ramp_numerator, sigma_delta_numerator, modulation_offset;
    logic [23:0] effective_numerator, phase_offset;
    logic [24:0] sigma_delta_denominator, effective_denominator, acc_den;
    logic [2:0]  ramp_segment, active_segment;
    logic [1:0]  modulator_order, dither_select, readback_pin_select;
    logic [1:0]  sleep_control;
    logic [7:0]  feedback_divider_low, rb, a_val;
    logic [31:0] seed;
    int          bad_count, cmp_count, pulse_count;

    synth_serial_config_regs #(.NUM_SEGMENTS(NSEG))
        synth_serial_config_regs_i (.*);
    host_cfg_model host_cfg_model_i (.*);

    always_comb
        case (readback_pin_select)
            // Released pins float high, so a dead enable shows up
            RB_MOD:  rb_line = modulation_pin_oe ? modulation_pin_out : 1'b1;
            RB_MUX:  rb_line = multiplexed_output_pin;
            RB_TRIGGER_PIN_ONE: rb_line = trigger_pin_one_oe
                                ? trigger_pin_one_out : 1'b1;
            default: rb_line = trigger_pin_two_oe
                               ? trigger_pin_two_out : 1'b1;
        endcase

    always @(posedge ref_clk)
        if (soft_reset_pulse)
            pulse_count <= pulse_count + 1;

    // --------------------
    // Helpers
    // --------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic den_ok(input logic [24:0] d);
        return d >= DEN_MIN && d <= DEN_MAX;
    endfunction

    function automatic logic [23:0] exp_num();
        logic [23:0] b;
        b = ramp_enable ? ramp_numerator : sigma_delta_numerator;
        return (modulation_pin_in && !modulation_is_phase) ? b + modulation_offset : b;
    endfunction

    task automatic chk(input logic [24:0] got, exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        host_cfg_model_i.xfer({112'h0, 1'b0, a, d}, 24, rb);
        wait_cyc(12);
    endtask

    // Data field all ones: a read must not write it
    task automatic rd(input logic [14:0] a, input logic [1:0] s,
                      output logic [7:0] r);
        readback_pin_select = s;
        wait_cyc(3);
        host_cfg_model_i.xfer({112'h0, 1'b1, a, 8'hff}, 24, r);
        wait_cyc(2);
    endtask

    task automatic mode_step();
        logic [31:0] r;
        logic [24:0] d;
        logic        z;
        r = rnd();
        ramp_enable         = r[0];
        modulation_pin_in   = r[1];
        modulation_is_phase = r[2];
        ramp_segment        = r[5:3];
        z                   = (r[7:6] == 2'h0);
        modulator_order     = z ? 2'h0 : r[9:8];
        dither_select       = z ? 2'h0 : r[11:10];
        r = rnd();
        sigma_delta_numerator = z ? 24'h0 : r[23:0];
        ramp_numerator        = r[31:8];
        r = rnd();
        d = r[26] ? DEN_MAX : r[24:0];
        if (!den_ok(d) && (ramp_enable || prev_ramp))
            d = DEN_MIN;
        sigma_delta_denominator = d;
        modulation_offset       = 24'(rnd() >> 8);
        wait_cyc(4);
        if (!ramp_enable && den_ok(d))
            acc_den = d;
        chk(25'(fractional_active), 25'(ramp_enable || !z), "frac");
        chk(25'(ramp_running), 25'(ramp_enable), "ramp");
        chk(effective_denominator, ramp_enable ? DEN_FORCED : acc_den, "den");
        chk(25'(effective_numerator), 25'(exp_num()), "num");
        chk(25'(phase_offset), (modulation_pin_in && modulation_is_phase)
            ? 25'(modulation_offset) : 25'h0, "phase");
        if (!ramp_enable || ramp_segment < NSEG)
            chk(25'(active_segment), ramp_enable ? 25'(ramp_segment) : 25'h0, "seg");
        prev_ramp = ramp_enable;
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // --------------------
    // Stimulus
    // --------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    initial
    begin
        {resetn, modulation_pin_in, ramp_enable, modulation_is_phase} = 4'h0;
        {ramp_numerator, sigma_delta_numerator, modulation_offset} = 72'h0;
        {ramp_segment, modulator_order, dither_select} = 7'h00;
        sigma_delta_denominator = DEN_MAX;
        readback_pin_select = RB_MUX;
        clk_en = 1'b1;
        acc_den = DEN_MAX;
        prev_ramp = 1'b0;
        seed = 32'h0043;
        bad_count = 0;
        cmp_count = 0;
        pulse_count = 0;
        wait_cyc(2);
        resetn = 1'b1;
        wait_cyc(5);
        chk(25'(sleep_control), 25'h0, "sleep reset");
        chk(25'(feedback_divider_low), 25'h0, "div reset");
        chk(effective_denominator, DEN_MAX, "den reset");
        rd(ADDR_FIXED, RB_MUX, rb);
        chk(25'(rb), 25'(FIXED_VALUE), "fixed reg");
        for (int k = 0; k < 4; k++)
        begin
            wr(ADDR_CTRL, 8'(k));
            chk(25'(sleep_control), 25'(k), "sleep");
            rd(ADDR_CTRL, 2'(k), rb);
            chk(25'(rb), 25'(k), "read pin");
        end
        // One frame from 0x10 down to 0x2, zeros in between
        a_val = 8'(rnd() >> 24);
        host_cfg_model_i.xfer({1'b0, ADDR_NDIV, a_val, 104'h0, 8'h01}, 136, rb);
        wait_cyc(12);
        chk(25'(feedback_divider_low), 25'(a_val), "stream top");
        chk(25'(sleep_control), 25'h1, "stream low");
        host_cfg_model_i.xfer({116'h0, 1'b0, ADDR_NDIV, ~a_val[7:4]}, 20, rb);
        wait_cyc(12);
        chk(25'(feedback_divider_low), 25'(a_val), "partial byte");
        rd(15'h0005, RB_TRIGGER_PIN_TWO, rb);
        chk(25'(rb), 25'h0, "unmapped");
        rd(ADDR_NDIV, RB_TRIGGER_PIN_ONE, rb);
        chk(25'(rb), 25'(a_val), "div read");
        chk(25'(feedback_divider_low), 25'(a_val), "read no write");
        wr(ADDR_CTRL, 8'h07);
        chk(25'(sleep_control), 25'h0, "soft sleep");
        chk(25'(feedback_divider_low), 25'h0, "soft div");
        chk(25'(pulse_count), 25'h1, "soft pulse");
        rd(ADDR_CTRL, RB_MOD, rb);
        chk(25'(rb), 25'h0, "soft bit");
        repeat (40) mode_step();
        // Enable low must freeze the core against a mode change
        clk_en = 1'b0;
        ramp_enable = ~ramp_enable;
        wait_cyc(3);
        chk(25'(ramp_running), 25'(!ramp_enable), "freeze");
        clk_en = 1'b1;
        give_verdict();
    end
endmodule

bind synth_serial_config_regs synth_cfg_sva #(.NUM_SEGMENTS(NUM_SEGMENTS))
    synth_cfg_sva_i (.*);
